// *** pmi_lane.sv ***
// Purpose: one lane of the pipe mac-side interface
// Assumes: phy logic runs on core_clk, so no synchronisers
// Notes:   one instance per lane
`timescale 1ns/1ps
`include "pmi_map.svh"
module pmi_lane (
  input  wire logic               core_clk,    // pipe clock
  input  wire logic               reset,       // async, high
  input  wire logic               ce,          // clock enable
  input  wire logic               gen3,        // wide rate active
  input  wire logic               done_clear,  // new request issued
  input  wire pmi_pkg::pmi_coeff_type coeff_in, // wanted coefficients
  input  wire logic [2:0]         preset_in,   // wanted preset
  input  wire logic               polarity_in, // invert rx
  input  wire logic [2:0]         infer_in,    // inference code
  input  wire logic [1:0]         power_in,    // held power state
  input  wire pmi_pkg::pmi_rx_type phy_rx,     // from phy
  output pmi_pkg::pmi_tx_type     phy_tx,      // to phy
  output pmi_pkg::pmi_rx_type     user_rx,     // captured receive
  output logic                    done_seen    // sticky completion
);
  import pmi_pkg::*;

  pmi_tx_type next_tx;
  pmi_rx_type next_rx;
  logic       next_done;
  wire  [`PMI_WIDE_W-1:0] narrow_word =
    {{(`PMI_WIDE_W-`PMI_NARROW_W){1'b0}},
     phy_rx.rx_lane_word[`PMI_NARROW_W-1:0]};
  // a held word is trimmed too, so a gen3 word cannot outlive a rate drop
  wire  [`PMI_WIDE_W-1:0] held_word = gen3 ? user_rx.rx_lane_word :
    {{(`PMI_WIDE_W-`PMI_NARROW_W){1'b0}},
     user_rx.rx_lane_word[`PMI_NARROW_W-1:0]};

  always_comb begin
    next_tx                       = phy_tx;
    next_tx.tx_coeff_current      = gen3 ? coeff_in : '0;  // see RL3
    next_tx.rx_preset_current     = gen3 ? preset_in : 3'h0; // see RL4
    next_tx.idle_inference_select = infer_in;
    next_tx.power_state_request   = power_in;  // see RL11
    next_tx.rx_invert_polarity    = polarity_in; // see RL17
    next_rx                  = phy_rx;
    // word only refreshed under lock, so stale symbols never leak
    next_rx.rx_lane_word     = !phy_rx.rx_lock_valid ? held_word
                             : gen3 ? phy_rx.rx_lane_word
                             : narrow_word;              // see RL1 RL14 RL20
    next_rx.rx_symbol_kind   = gen3 ? 4'h0
                             : {3'h0, phy_rx.rx_symbol_kind[0]}; // see RL15
    next_rx.rx_block_start   = gen3 & phy_rx.rx_block_start;     // see RL13
  end

  // a completion in the clearing cycle is kept: set wins
  assign next_done = phy_rx.phy_done_status | (done_seen & ~done_clear);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      phy_tx    <= '0;
      user_rx   <= '0;
      done_seen <= 1'b0;
    end else if (ce) begin
      phy_tx    <= next_tx;
      user_rx   <= next_rx;
      done_seen <= next_done;  // see RL10
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_coeff_low;
    ce && !gen3 |=> phy_tx.tx_coeff_current == '0;
  endproperty
  a_coeff_low: assert property (p_coeff_low) // see RL3
    else $error("coefficients not zero below gen3");

  property p_preset;
    ce && gen3 |=> phy_tx.rx_preset_current == $past(preset_in);
  endproperty
  a_preset: assert property (p_preset) // see RL4
    else $error("preset not driven at gen3");

  property p_narrow;
    ce && !gen3 |=> user_rx.rx_lane_word[`PMI_WIDE_W-1:`PMI_NARROW_W] == '0;
  endproperty
  a_narrow: assert property (p_narrow) // see RL14
    else $error("upper bytes used in narrow mode");

  property p_polarity;
    ce |=> phy_tx.rx_invert_polarity == $past(polarity_in);
  endproperty
  a_polarity: assert property (p_polarity) // see RL17
    else $error("polarity not forwarded");

  property p_done_set;
    ce && phy_rx.phy_done_status |=> done_seen;
  endproperty
  a_done_set: assert property (p_done_set) // see RL10
    else $error("completion lost");
endmodule

// *** pmi_map.svh ***
// Purpose: constants of the pipe mac-side interface
// Assumes: included by the package and by design files by bare name
// Notes:   definitions only
`ifndef PMI_MAP_SVH
`define PMI_MAP_SVH

// per-lane data widths and maximum lane count
`define PMI_NARROW_W      8
`define PMI_WIDE_W        32
`define PMI_MAX_LANES     8

// rate field codes; gen3 is 1x, driven as 10
`define PMI_RATE_GEN1     2'b00
`define PMI_RATE_GEN2     2'b01
`define PMI_RATE_GEN3     2'b10
`define PMI_RATE_RSVD     2'b11

// power state codes
`define PMI_PWR_P0        2'b00
`define PMI_PWR_P0S       2'b01
`define PMI_PWR_P1        2'b10
`define PMI_PWR_P2        2'b11

// idle inference selector codes
`define PMI_INFER_NONE    3'b000
`define PMI_INFER_COMSKP  3'b100
`define PMI_INFER_TS      3'b101
`define PMI_INFER_EXIT_UI 3'b110
`define PMI_INFER_EXIT_US 3'b111

// coefficient field positions
`define PMI_PRE_LSB       0
`define PMI_MAIN_LSB      6
`define PMI_POST_LSB      12
`define PMI_COEFF_W       6

`endif

// *** pmi_phy_model.sv ***
// Purpose: behavioural phy on the far side of the pipe mac interface
// Assumes: shares core_clk with the mac
// Notes:   done latency and receive stimulus come from the bench
`timescale 1ns/1ps
module pmi_phy_model #(
  parameter int NUM_LANES = 8
) (
  input  wire logic        core_clk,  // pipe clock
  input  wire logic        reset,     // async, high
  input  wire logic [7:0]  delay,     // done latency
  input  wire logic [31:0] stim,      // random source
  input  wire logic [1:0]  phy_rate,  // rate from mac
  input  wire pmi_pkg::pmi_tx_type [NUM_LANES-1:0] phy_tx, // controls
  output pmi_pkg::pmi_rx_type [NUM_LANES-1:0]      phy_rx  // receive
);
  import pmi_pkg::*;
  logic [1:0]  last_rate;
  logic [1:0]  last_pwr [NUM_LANES];
  int          wait_cnt [NUM_LANES];
  logic [31:0] w;

  // a new rate or power restarts the timer, so a split request is
  // answered once, after its last part
  always @(posedge core_clk or posedge reset) begin
    for (int l = 0; l < NUM_LANES; l++) begin
      if (reset) begin
        wait_cnt[l] = 0;
        last_pwr[l] = 2'b00;
        phy_rx[l] <= '0;
      end else begin
        w = (stim << l) | (stim >> (32 - l));
        if (phy_tx[l].rx_invert_polarity)
          w = ~w;
        phy_rx[l].rx_lane_word <= w;
        phy_rx[l].rx_symbol_kind <= w[3:0];
        phy_rx[l].rx_block_start <= phy_rate[1] & w[4];
        phy_rx[l].rx_idle_detected <= w[5];
        phy_rx[l].rx_lock_valid <= w[6] | w[7];
        phy_rx[l].rx_status_code <= w[10:8];
        phy_rx[l].phy_done_status <= (wait_cnt[l] == 1);
        if (phy_tx[l].power_state_request != last_pwr[l] ||
            phy_rate != last_rate)
          wait_cnt[l] = delay + l + 1;
        else if (wait_cnt[l] > 0)
          wait_cnt[l] = wait_cnt[l] - 1;
        last_pwr[l] = phy_tx[l].power_state_request;
      end
    end
    last_rate = reset ? 2'b00 : phy_rate;
  end
endmodule

// *** pmi_pipe_mac.sv ***
// Purpose: mac-side pipe interface, lanes 0 to n-1
// Assumes: core_clk is the pipe interface clock shared with the phy
// Notes:   simulation-only interface; rate is common to all lanes
`timescale 1ns/1ps
`include "pmi_map.svh"
// Contract
// RL1: lane data is 8 bits at gen1/gen2, 32 bits at gen3.
// RL2: every lane signal is replicated for lanes one to seven.
// RL3: gen3 coefficients: pre 5:0, main 11:6, post 17:12.
// RL4: gen3 drives a 3-bit current receiver preset per lane.
// RL5: inference selector msb is zero when no inference is needed.
// RL6: code 100 infers from missing com/skp in 128 us, gen1/gen2.
// RL7: code 101 infers from missing ts1/ts2 in 1280 ui, gen1/gen2.
// RL8: code 110 infers missing idle exit, 2000/16000 ui gen1/gen2.
// RL9: code 111 infers missing idle exit in 128 us, gen1 only.
// RL10: phy signals completion of requests on its status input.
// RL11: 2-bit power field selects p0, p0s, p1 or p2.
// RL12: 2-bit rate field; 00 is gen1, 11 is reserved.
// RL13: phy marks first word of each gen3 block.
// RL14: receive bus is 32 bits; only low byte used in narrow modes.
// RL15: one data/control flag per byte, bit 0 lowest byte, gen1/gen2.
// RL16: phy flags electrical idle on each receiver.
// RL17: polarity control makes the phy invert receive data.
// RL18: gen3 runs eq phases 2 and 3 unless partner bypasses them.
// RL19: rate 01 is gen2 and 1x is gen3.
// RL20: phy raises valid on symbol lock with valid data.
// RL21: phy reports 3-bit receive status per lane.
// RL22: all signals are clocked by the pipe interface clock.
// RL23: hold power or rate request until completion, then allow next.
module pmi_pipe_mac #(
  parameter int NUM_LANES = `PMI_MAX_LANES
) (
  input  wire logic                  core_clk,       // pipe clock
  input  wire logic                  reset,          // async, high
  input  wire logic                  ce,             // clock enable
  input  wire logic                  change_req,     // request pulse
  input  wire logic [1:0]            req_power,      // wanted power state
  input  wire logic [1:0]            req_rate,       // wanted rate code
  output logic                       change_busy,    // waiting on phy
  output logic                       change_done,    // completion pulse
  output logic                       change_refused, // refused pulse
  input  wire logic                  infer_needed,   // state needs it
  input  wire pmi_pkg::pmi_infer_kind_type infer_kind, // mechanism
  input  wire logic                  infer_exit_long, // 128 us exit
  input  wire logic                  eq_start,       // begin phase 1
  input  wire logic                  eq_partner_bypass, // skip 2 and 3
  input  wire logic                  eq_phase_done,  // phase finished
  output pmi_pkg::pmi_eq_state_type  eq_state,       // current phase
  input  wire pmi_pkg::pmi_coeff_type coeff_in,      // tx coefficients
  input  wire logic [2:0]            preset_in,      // rx preset
  input  wire logic [NUM_LANES-1:0]  polarity_in,    // per-lane invert
  output logic [1:0]                 phy_rate,       // rate to phy
  output pmi_pkg::pmi_tx_type [NUM_LANES-1:0] phy_tx, // lane outputs
  input  wire pmi_pkg::pmi_rx_type [NUM_LANES-1:0] phy_rx, // lane inputs
  output pmi_pkg::pmi_rx_type [NUM_LANES-1:0] user_rx // captured rx
);
  import pmi_pkg::*;

  if (NUM_LANES < 1 || NUM_LANES > `PMI_MAX_LANES) begin : g_bad_lanes
    $error("NUM_LANES must lie between 1 and 8");
  end

  pmi_chg_state_type     chg_state;
  pmi_chg_state_type     next_chg_state;
  pmi_eq_state_type      next_eq_state;
  logic [1:0]            power_q;
  logic [1:0]            next_power;
  logic [1:0]            next_rate;
  logic [2:0]            next_infer;
  logic [NUM_LANES-1:0]  lane_done;

  wire chg_idle    = chg_state == PMI_CHG_IDLE;
  wire rate_ok     = req_rate != `PMI_RATE_RSVD;  // see RL12
  // a request while busy is refused, so the held value stays put
  wire start_chg   = ce & change_req & chg_idle & rate_ok; // see RL23
  wire refuse_chg  = ce & change_req & ~(chg_idle & rate_ok);
  wire all_done    = &lane_done;
  wire finish_chg  = ce & ~chg_idle & all_done;   // see RL10 RL23
  wire gen3        = phy_rate[1];                 // see RL19
  wire gen1        = phy_rate == `PMI_RATE_GEN1;

  assign change_busy = ~chg_idle;

  // rate and power are only loaded at the start of a change
  always_comb begin
    next_chg_state = chg_state;
    next_power     = power_q;
    next_rate      = phy_rate;
    case (chg_state)
      PMI_CHG_IDLE: begin
        if (start_chg) begin
          next_chg_state = PMI_CHG_WAIT;
          next_power     = req_power;      // see RL11
          next_rate      = req_rate[1] ? `PMI_RATE_GEN3 : req_rate; // RL19
        end
      end
      PMI_CHG_WAIT: begin
        if (all_done) begin
          next_chg_state = PMI_CHG_IDLE;
        end
      end
      default: begin
        next_chg_state = PMI_CHG_IDLE;
      end
    endcase
  end

  // gen3 defines no inference code, so the selector stays at none
  always_comb begin
    next_infer = `PMI_INFER_NONE;                 // see RL5
    if (infer_needed && !gen3) begin
      case (infer_kind)
        PMI_KIND_COMSKP: next_infer = `PMI_INFER_COMSKP; // see RL6
        PMI_KIND_TS:     next_infer = `PMI_INFER_TS;     // see RL7
        PMI_KIND_EXIT: begin
          // 128 us exit window exists at gen1 only
          next_infer = (infer_exit_long && gen1) ? `PMI_INFER_EXIT_US
                                                 : `PMI_INFER_EXIT_UI;
        end                                              // see RL8 RL9
        default:         next_infer = `PMI_INFER_NONE;
      endcase
    end
  end

  always_comb begin
    next_eq_state = eq_state;
    case (eq_state)
      PMI_EQ_OFF, PMI_EQ_DONE: begin
        if (eq_start && gen3) begin
          next_eq_state = PMI_EQ_P1;
        end
      end
      PMI_EQ_P1: begin
        if (eq_phase_done) begin
          next_eq_state = eq_partner_bypass ? PMI_EQ_DONE
                                            : PMI_EQ_P2;  // see RL18
        end
      end
      PMI_EQ_P2: begin
        if (eq_phase_done) begin
          next_eq_state = PMI_EQ_P3;      // see RL18
        end
      end
      PMI_EQ_P3: begin
        if (eq_phase_done) begin
          next_eq_state = PMI_EQ_DONE;
        end
      end
      default: begin
        next_eq_state = PMI_EQ_OFF;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin  // see RL22
    if (reset) begin
      chg_state <= PMI_CHG_IDLE;
      power_q   <= `PMI_PWR_P0;
      phy_rate  <= `PMI_RATE_GEN1;
      eq_state  <= PMI_EQ_OFF;
    end else if (ce) begin
      chg_state <= next_chg_state;
      power_q   <= next_power;
      phy_rate  <= next_rate;
      eq_state  <= next_eq_state;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      change_done    <= 1'b0;
      change_refused <= 1'b0;
    end else if (ce) begin
      change_done    <= finish_chg;
      change_refused <= refuse_chg;
    end
  end

  // all lanes share rate, coefficients and inference code
  for (genvar i = 0; i < NUM_LANES; i++) begin : g_lane  // see RL2
    pmi_lane u_lane (
      .core_clk    (core_clk),
      .reset       (reset),
      .ce          (ce),
      .gen3        (gen3),
      .done_clear  (start_chg),
      .coeff_in    (coeff_in),
      .preset_in   (preset_in),
      .polarity_in (polarity_in[i]),
      .infer_in    (next_infer),
      .power_in    (power_q),
      .phy_rx      (phy_rx[i]),
      .phy_tx      (phy_tx[i]),
      .user_rx     (user_rx[i]),
      .done_seen   (lane_done[i])
    );
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  wire [2:0] sel0 = phy_tx[0].idle_inference_select;

  property p_no_infer;
    ce && !infer_needed |=> sel0[2] == 1'b0;
  endproperty
  a_no_infer: assert property (p_no_infer) // see RL5
    else $error("selector msb set without inference");

  property p_comskp;
    ce && infer_needed && !gen3 && infer_kind == PMI_KIND_COMSKP
      |=> sel0 == `PMI_INFER_COMSKP;
  endproperty
  a_comskp: assert property (p_comskp) // see RL6
    else $error("com/skp inference code wrong");

  property p_ts;
    ce && infer_needed && !gen3 && infer_kind == PMI_KIND_TS
      |=> sel0 == `PMI_INFER_TS;
  endproperty
  a_ts: assert property (p_ts) // see RL7
    else $error("ts inference code wrong");

  property p_exit_ui;
    ce && infer_needed && phy_rate == `PMI_RATE_GEN2
      && infer_kind == PMI_KIND_EXIT |=> sel0 == `PMI_INFER_EXIT_UI;
  endproperty
  a_exit_ui: assert property (p_exit_ui) // see RL8
    else $error("gen2 exit inference code wrong");

  property p_exit_us;
    sel0 == `PMI_INFER_EXIT_US |-> $past(gen1) && $past(infer_exit_long);
  endproperty
  a_exit_us: assert property (p_exit_us) // see RL9
    else $error("128 us exit code outside gen1");

  property p_rate_legal;
    phy_rate != `PMI_RATE_RSVD;
  endproperty
  a_rate_legal: assert property (p_rate_legal) // see RL12
    else $error("reserved rate driven");

  property p_hold;
    change_busy && !finish_chg |=> $stable(phy_rate) && $stable(power_q);
  endproperty
  a_hold: assert property (p_hold) // see RL23
    else $error("request changed before completion");

  property p_power_out;
    start_chg ##1 ce[*1] |=> phy_tx[0].power_state_request == $past(power_q);
  endproperty
  a_power_out: assert property (p_power_out) // see RL11
    else $error("power request not forwarded");

  sequence s_p1_end;
    ce && eq_state == PMI_EQ_P1 && eq_phase_done;
  endsequence

  property p_eq_skip;
    s_p1_end ##0 eq_partner_bypass |=> eq_state == PMI_EQ_DONE;
  endproperty
  a_eq_skip: assert property (p_eq_skip) // see RL18
    else $error("bypassed phases not skipped");

  property p_eq_full;
    s_p1_end ##0 !eq_partner_bypass |=> eq_state == PMI_EQ_P2;
  endproperty
  a_eq_full: assert property (p_eq_full) // see RL18
    else $error("phase 2 not entered");
endmodule

// *** pmi_pkg.sv ***
// Purpose: types of the pipe mac-side interface
// Assumes: pmi_map.svh holds the codes
// Notes:   structs carry the per-lane signal groups
`include "pmi_map.svh"
package pmi_pkg;

  typedef struct packed {
    logic [`PMI_COEFF_W-1:0] post;
    logic [`PMI_COEFF_W-1:0] main;
    logic [`PMI_COEFF_W-1:0] pre;
  } pmi_coeff_type;

  typedef struct packed {
    pmi_coeff_type  tx_coeff_current;
    logic [2:0]     rx_preset_current;
    logic [2:0]     idle_inference_select;
    logic [1:0]     power_state_request;
    logic           rx_invert_polarity;
  } pmi_tx_type;

  typedef struct packed {
    logic [`PMI_WIDE_W-1:0] rx_lane_word;
    logic [3:0]             rx_symbol_kind;
    logic                   rx_block_start;
    logic                   rx_idle_detected;
    logic                   rx_lock_valid;
    logic [2:0]             rx_status_code;
    logic                   phy_done_status;
  } pmi_rx_type;

  typedef enum logic [1:0] {
    PMI_KIND_COMSKP = 2'b00,
    PMI_KIND_TS     = 2'b01,
    PMI_KIND_EXIT   = 2'b10
  } pmi_infer_kind_type;

  typedef enum logic [1:0] {
    PMI_CHG_IDLE = 2'b01,
    PMI_CHG_WAIT = 2'b10
  } pmi_chg_state_type;

  typedef enum logic [4:0] {
    PMI_EQ_OFF  = 5'b00001,
    PMI_EQ_P1   = 5'b00010,
    PMI_EQ_P2   = 5'b00100,
    PMI_EQ_P3   = 5'b01000,
    PMI_EQ_DONE = 5'b10000
  } pmi_eq_state_type;

endpackage

// *** pmi_tb.sv ***
// Purpose: self-checking bench of the pipe mac-side interface
// Assumes: pmi_phy_model answers every power or rate change
// Notes:   lane outputs are compared on every enabled edge outside reset
`timescale 1ns/1ps
module tb;
  import pmi_pkg::*;
  localparam int NL = 8;
  logic             core_clk = 1'b0;
  logic             reset = 1'b1;
  logic             ce = 1'b1;
  logic             change_req = 1'b0;
  logic [1:0]       req_power = 2'b00;
  logic [1:0]       req_rate = 2'b00;
  logic             change_busy;
  logic             change_done;
  logic             change_refused;
  logic             infer_needed = 1'b0;
  logic [1:0]       kind_bits = 2'b00;
  logic             infer_exit_long = 1'b0;
  logic             eq_start = 1'b0;
  logic             eq_partner_bypass = 1'b0;
  logic             eq_phase_done = 1'b0;
  pmi_eq_state_type eq_state;
  pmi_coeff_type    coeff_in = '0;
  logic [2:0]       preset_in = 3'h0;
  logic [NL-1:0]    polarity_in = '0;
  logic [1:0]       phy_rate;
  pmi_tx_type [NL-1:0] phy_tx;
  pmi_rx_type [NL-1:0] phy_rx;
  pmi_rx_type [NL-1:0] user_rx;
  logic [7:0]       delay = 8'h02;
  logic [31:0]      stim = 32'h0;
  logic [31:0]      rnd = 32'h12;
  logic [1:0]       rate_q = 2'b00;
  logic [1:0]       pwr_q = 2'b00;
  logic [31:0]      exp_word [NL];
  pmi_tx_type       etx [NL];
  pmi_rx_type       erx [NL];
  logic [1:0]       rates [8] = '{2'b01, 2'b10, 2'b11, 2'b00,
                                  2'b11, 2'b01, 2'b00, 2'b10};
  int               num_errors = 0;
  int               checks_done = 0;

  always #20 core_clk = ~core_clk;

  pmi_pipe_mac #(.NUM_LANES(NL)) pmi_pipe_mac_i (
    .core_clk(core_clk), .reset(reset), .ce(ce),
    .change_req(change_req), .req_power(req_power),
    .req_rate(req_rate), .change_busy(change_busy),
    .change_done(change_done), .change_refused(change_refused),
    .infer_needed(infer_needed),
    .infer_kind(pmi_infer_kind_type'(kind_bits)),
    .infer_exit_long(infer_exit_long), .eq_start(eq_start),
    .eq_partner_bypass(eq_partner_bypass),
    .eq_phase_done(eq_phase_done), .eq_state(eq_state),
    .coeff_in(coeff_in), .preset_in(preset_in),
    .polarity_in(polarity_in), .phy_rate(phy_rate),
    .phy_tx(phy_tx), .phy_rx(phy_rx), .user_rx(user_rx));

  pmi_phy_model #(.NUM_LANES(NL)) pmi_phy_model_i (
    .core_clk(core_clk), .reset(reset), .delay(delay), .stim(stim),
    .phy_rate(phy_rate), .phy_tx(phy_tx), .phy_rx(phy_rx));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [2:0] f_infer(input logic n,
      input logic [1:0] k, input logic lg, input logic [1:0] r);
    if (!n || r[1] || k == 2'b11)
      return 3'b000;
    if (k == 2'b00)
      return 3'b100;
    if (k == 2'b01)
      return 3'b101;
    return (lg && r == 2'b00) ? 3'b111 : 3'b110;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp,
      input string what);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s seen %h want %h", $time, what,
               seen, exp);
    end
  endtask

  task automatic summarize;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic step;
    @(posedge core_clk);
    #2;
  endtask

  task automatic do_reset;
    reset <= 1'b1;
    rate_q = 2'b00;
    pwr_q = 2'b00;
    for (int l = 0; l < NL; l++)
      exp_word[l] = '0;
    repeat (7) @(posedge core_clk);
    step();
    check(phy_rate, 2'b00, "reset rate");
    check(eq_state, PMI_EQ_OFF, "reset eq");
    check(|{phy_tx, user_rx, change_busy, change_done}, 1'b0, "reset");
    reset <= 1'b0;
  endtask

  task automatic change(input logic [1:0] p, input logic [1:0] r);
    int k;
    change_req <= 1'b1;
    req_power <= p;
    req_rate <= r;
    step();
    change_req <= 1'b0;
    if (r == 2'b11) begin
      check(change_refused, 1'b1, "reserved rate");
      check(change_busy, 1'b0, "reserved busy");
    end else begin
      rate_q = r;
      pwr_q = p;
      check(change_busy, 1'b1, "busy");
      check(phy_rate, r, "rate applied");
      step();
      change_req <= 1'b1;
      req_power <= ~p;
      step();
      change_req <= 1'b0;
      check(change_refused, 1'b1, "request while busy");
      k = 0;
      while (change_done !== 1'b1 && k < 300) begin
        step();
        k++;
      end
      check(change_done, 1'b1, "completion");
      check(change_busy, 1'b0, "busy cleared");
    end
    check(phy_rate, rate_q, "rate held");
  endtask

  task automatic phase_end;
    eq_phase_done <= 1'b1;
    step();
    eq_phase_done <= 1'b0;
    // a quiet edge, so the next pulse is a fresh assignment
    step();
  endtask

  task automatic eq_run(input logic byp);
    eq_partner_bypass <= byp;
    eq_start <= 1'b1;
    step();
    eq_start <= 1'b0;
    check(eq_state, PMI_EQ_P1, "eq phase 1");
    phase_end();
    if (!byp) begin
      check(eq_state, PMI_EQ_P2, "eq phase 2");
      phase_end();
      check(eq_state, PMI_EQ_P3, "eq phase 3");
      phase_end();
    end
    check(eq_state, PMI_EQ_DONE, "eq done");
  endtask

  always @(posedge core_clk) begin
    #2;
    rnd <= lfsr(rnd);
    stim <= rnd;
    infer_needed <= rnd[0];
    kind_bits <= rnd[2:1];
    infer_exit_long <= rnd[3];
    preset_in <= rnd[6:4];
    coeff_in <= rnd[29:12];
    polarity_in <= rnd[31:24];
  end

  // expectations use the values from before the edge
  always @(posedge core_clk) begin
    if (!reset && ce) begin
      for (int l = 0; l < NL; l++) begin
        etx[l].tx_coeff_current = rate_q[1] ? coeff_in : '0;
        etx[l].rx_preset_current = rate_q[1] ? preset_in : 3'h0;
        etx[l].idle_inference_select =
          f_infer(infer_needed, kind_bits, infer_exit_long, rate_q);
        etx[l].power_state_request = pwr_q;
        etx[l].rx_invert_polarity = polarity_in[l];
        erx[l] = phy_rx[l];
        if (!phy_rx[l].rx_lock_valid)
          erx[l].rx_lane_word = exp_word[l];
        if (!rate_q[1])
          erx[l].rx_lane_word[31:8] = '0;
        erx[l].rx_symbol_kind[3:1] = '0;
        if (rate_q[1])
          erx[l].rx_symbol_kind[0] = 1'b0;
        else
          erx[l].rx_block_start = 1'b0;
        exp_word[l] = erx[l].rx_lane_word;
      end
      #1;
      for (int l = 0; l < NL; l++) begin
        check(phy_tx[l], etx[l], "lane tx");
        check(user_rx[l], erx[l], "lane rx");
      end
    end
  end

  // a full pass needs about six hundred cycles; this allows 10000
  initial begin
    #400000;
    num_errors++;
    summarize();
  end

  initial begin
    do_reset();
    ce <= 1'b0;
    change_req <= 1'b1;
    req_power <= 2'b10;
    req_rate <= 2'b01;
    repeat (3) step();
    check(change_busy, 1'b0, "ce low busy");
    check(phy_rate, 2'b00, "ce low rate");
    ce <= 1'b1;
    change_req <= 1'b0;
    eq_start <= 1'b1;
    step();
    eq_start <= 1'b0;
    check(eq_state, PMI_EQ_OFF, "eq at gen1");
    for (int i = 0; i < 8; i++) begin
      delay <= i[0] ? 8'h19 : 8'h02;
      change(pwr_q + 2'h1, rates[i]);
      repeat (40) step();
    end
    eq_run(1'b1);
    eq_run(1'b0);
    repeat (50) step();
    do_reset();
    repeat (20) step();
    summarize();
  end
endmodule
